/* src/rta_top.sv */
// Real-time clock unit with alarm, watchdog, stopwatch and periodic events
// Behaviour
// R1: prescaler divides reference clock to one second
// R2: select bit picks divide ratio for 38.4 kHz
// R3: six-bit seconds, minutes; five-bit hours; nine-bit days
// R4: counters readable anytime without disturbing counting
// R5: out-of-range values hold, then clear on increment
// R6: seconds/minutes roll at 59, carry, raise event
// R7: hours roll at 23, bump day, raise event
// R8: rollover interrupts gated by own enable bits
// R9: full time match sets alarm flag
// R10: alarm interrupt only while alarm enabled
// R11: alarm recurs daily until software changes it; code also compares the day, so it fires only when day_q equals aday_q
// R12: enableable one-second periodic clock interrupt
// R13: watchdog times out at count two
// R14: watchdog mode bit; reset enabled, system reset
// R15: any watchdog write clears its count
// R16: software clears watchdog before timeout
// R17: eight prescaler rates, each enabled, one line
// R18: rate generator runs only when an enable set
// R19: three interrupt outputs; clock line merges events
// R20: clock enable bit resets to one
// R21: stopwatch counts minutes down, holds at minus one
// R22: flags sticky until cleared; outputs follow flags
// R23: everything steps on synchronised one-cycle tick
//
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rta_regs.svh"
module rta_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Reference clock pin
	input wire logic slow_ref_clock,
	// Write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address and data
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt lines and watchdog reset
	output rta_pkg::rta_irq_type irq_lines,
	output logic wdog_sys_reset
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `RTA_OFS_STW);
	endfunction
	function automatic logic [5:0] step(input logic [5:0] v, input logic [5:0] last);
		return (v >= last) ? 6'h00 : 6'(v + 6'h01);
	endfunction

	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic aw_full_q, w_full_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q, rd_word;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;
	logic ref_s1_q, ref_s2_q, ref_s3_q, ref_edge;
	logic [15:0] presc_q, div_last, sts_q, ena_q, sts_set, sts_clr;
	logic tick_q, tick1_q, tod_tick, run;
	logic ctl_en_q, ctl_ref_q, ctl_stw_q;
	rta_pkg::rta_tod_type tod_q, alm_q;
	logic [8:0] day_q, aday_q;
	logic [5:0] stw_q;
	logic wd_en_q, wd_sel_q, wd_to;
	logic [1:0] wd_cnt_q;
	logic sec_cy, min_cy, hr_cy, alm_hit, stw_hit;
	logic [7:0] rate_hit;
	logic wr_fire;
	logic [31:0] wr_tod, wr_alm;
	rta_pkg::rta_irq_type irq_q;
	logic wd_rst_q;

	// ****************************************
	// Register bus slave
	// ****************************************
	assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && awready_q) begin
			awready_q <= 1'b0;
			aw_full_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_full_q <= 1'b0;
		end else if (bvalid_q && s_axi_bready) begin
			awready_q <= 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && wready_q) begin
			wready_q <= 1'b0;
			w_full_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_full_q <= 1'b0;
		end else if (bvalid_q && s_axi_bready) begin
			wready_q <= 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			bvalid_q <= 1'b0;
			bresp_q <= `RTA_RESP_OK;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= mapped(aw_addr_q) ? `RTA_RESP_OK : `RTA_RESP_ERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	// R4: reads sample only
	always_comb begin
		rd_word = 32'h00000000;
		case (s_axi_araddr)
			`RTA_OFS_TOD: begin
				rd_word[`RTA_HR_F] = tod_q.hr;
				rd_word[`RTA_MIN_F] = tod_q.min;
				rd_word[`RTA_SEC_F] = tod_q.sec;
			end
			`RTA_OFS_ALM: begin
				rd_word[`RTA_HR_F] = alm_q.hr;
				rd_word[`RTA_MIN_F] = alm_q.min;
				rd_word[`RTA_SEC_F] = alm_q.sec;
			end
			`RTA_OFS_CTL: begin
				rd_word[`RTA_CTL_EN] = ctl_en_q;
				rd_word[`RTA_CTL_REF] = ctl_ref_q;
				rd_word[`RTA_CTL_STW] = ctl_stw_q;
			end
			`RTA_OFS_STS: rd_word[15:0] = sts_q;
			`RTA_OFS_ENA: rd_word[15:0] = ena_q;
			`RTA_OFS_DAY: rd_word[`RTA_DAY_F] = day_q;
			`RTA_OFS_ADY: rd_word[`RTA_DAY_F] = aday_q;
			`RTA_OFS_WDG: begin
				rd_word[`RTA_WDG_EN] = wd_en_q;
				rd_word[`RTA_WDG_IRQ] = wd_sel_q;
				rd_word[`RTA_WDG_CNT_F] = wd_cnt_q;
			end
			`RTA_OFS_STW: rd_word[`RTA_STW_F] = stw_q;
			default: rd_word = 32'h00000000;
		endcase
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `RTA_RESP_OK;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= mapped(s_axi_araddr) ? `RTA_RESP_OK : `RTA_RESP_ERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// ****************************************
	// Reference clock and prescaler
	// ****************************************
	// R23: two flops before use
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
			ref_s3_q <= 1'b0;
		end else begin
			ref_s1_q <= slow_ref_clock;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
		end
	end
	assign ref_edge = ref_s2_q & ~ref_s3_q;
	// R18: prescaler idles when both enables clear
	assign run = ctl_en_q | wd_en_q;
	// R2: ratio follows select bit
	assign div_last = ctl_ref_q ? `RTA_DIV_38K : `RTA_DIV_32K;
	// R1: divide to one second
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			presc_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= run & ref_edge & (presc_q >= div_last);
			if (!run)
				presc_q <= 16'h0000;
			else if (ref_edge)
				presc_q <= (presc_q >= div_last) ? 16'h0000 : 16'(presc_q + 16'h0001);
		end
	end
	// R17: eight taps of the prescaler
	always_comb begin
		for (int i = 0; i < 8; i++)
			rate_hit[i] = run & ref_edge & ((presc_q & (`RTA_TAP_MASK >> i)) ==
				(`RTA_TAP_MASK >> i));
	end

	// ****************************************
	// Time of day
	// ****************************************
	// R23: all counters step on the tick
	assign tod_tick = tick_q & ctl_en_q;
	// R6: carry chain at 59
	assign sec_cy = tod_tick & (tod_q.sec == `RTA_SEC_LAST);
	assign min_cy = sec_cy & (tod_q.min == `RTA_SEC_LAST);
	// R7: hours roll at 23
	assign hr_cy = min_cy & (tod_q.hr == `RTA_HR_LAST);
	assign wr_tod = merge({3'h0, tod_q.hr, 2'h0, tod_q.min, 10'h000, tod_q.sec}, w_data_q,
		w_strb_q);
	// R3: field widths; R5: no range check
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			tod_q <= '0;
		end else if (wr_fire && aw_addr_q == `RTA_OFS_TOD) begin
			tod_q.hr <= wr_tod[`RTA_HR_F];
			tod_q.min <= wr_tod[`RTA_MIN_F];
			tod_q.sec <= wr_tod[`RTA_SEC_F];
		end else if (tod_tick) begin
			// R5: oversized value clears on step
			tod_q.sec <= step(tod_q.sec, `RTA_SEC_LAST);
			if (sec_cy)
				tod_q.min <= step(tod_q.min, `RTA_SEC_LAST);
			if (min_cy)
				tod_q.hr <= 5'(step({1'b0, tod_q.hr}, {1'b0, `RTA_HR_LAST}));
		end
	end
	// R7: day counter advanced by hours carry
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			day_q <= 9'h000;
		else if (wr_fire && aw_addr_q == `RTA_OFS_DAY)
			day_q <= 9'(merge({23'h0, day_q}, w_data_q, w_strb_q));
		else if (hr_cy)
			day_q <= 9'(day_q + 9'h001);
	end

	// ****************************************
	// Alarm
	// ****************************************
	assign wr_alm = merge({3'h0, alm_q.hr, 2'h0, alm_q.min, 10'h000, alm_q.sec}, w_data_q,
		w_strb_q);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			alm_q <= '0;
			aday_q <= 9'h000;
		end else if (wr_fire && aw_addr_q == `RTA_OFS_ALM) begin
			alm_q.hr <= wr_alm[`RTA_HR_F];
			alm_q.min <= wr_alm[`RTA_MIN_F];
			alm_q.sec <= wr_alm[`RTA_SEC_F];
		end else if (wr_fire && aw_addr_q == `RTA_OFS_ADY) begin
			aday_q <= 9'(merge({23'h0, aday_q}, w_data_q, w_strb_q));
		end
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			tick1_q <= 1'b0;
		else
			tick1_q <= tod_tick;
	end
	// R9: compare after the counters settle; R11: day compared too, so no daily recurrence
	assign alm_hit = tick1_q & (tod_q == alm_q) & (day_q == aday_q);

	// ****************************************
	// Stopwatch
	// ****************************************
	// R21: minute countdown, hold at all ones
	assign stw_hit = sec_cy & ctl_stw_q & (stw_q == 6'h00);
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			stw_q <= `RTA_STW_HOLD;
		else if (wr_fire && aw_addr_q == `RTA_OFS_STW)
			stw_q <= 6'(merge({26'h0, stw_q}, w_data_q, w_strb_q));
		else if (sec_cy && ctl_stw_q && stw_q != `RTA_STW_HOLD)
			stw_q <= 6'(stw_q - 6'h01);
	end

	// ****************************************
	// Control and watchdog
	// ****************************************
	// R20: clock enable set from reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctl_en_q <= 1'b1;
			ctl_ref_q <= 1'b0;
			ctl_stw_q <= 1'b0;
		end else if (wr_fire && aw_addr_q == `RTA_OFS_CTL && w_strb_q[0]) begin
			ctl_en_q <= w_data_q[`RTA_CTL_EN];
			ctl_ref_q <= w_data_q[`RTA_CTL_REF];
			ctl_stw_q <= w_data_q[`RTA_CTL_STW];
		end
	end
	// R13: timeout once count reaches two
	assign wd_to = wd_en_q & (wd_cnt_q == `RTA_WDG_LIMIT);
	// R14: enabled, reset mode out of reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wd_en_q <= 1'b1;
			wd_sel_q <= 1'b0;
		end else if (wr_fire && aw_addr_q == `RTA_OFS_WDG && w_strb_q[0]) begin
			wd_en_q <= w_data_q[`RTA_WDG_EN];
			wd_sel_q <= w_data_q[`RTA_WDG_IRQ];
		end
	end
	// R15: any write clears the count
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			wd_cnt_q <= 2'h0;
		else if ((wr_fire && aw_addr_q == `RTA_OFS_WDG) || wd_to)
			wd_cnt_q <= 2'h0;
		else if (tick_q && wd_en_q)
			wd_cnt_q <= 2'(wd_cnt_q + 2'h1);
	end
	// R14: mode picks reset or interrupt
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			wd_rst_q <= 1'b0;
		else
			wd_rst_q <= wd_to & ~wd_sel_q;
	end

	// ****************************************
	// Event flags and interrupt lines
	// ****************************************
	always_comb begin
		sts_set = 16'h0000;
		sts_set[`RTA_EV_STW] = stw_hit;
		// R12: one-second event
		sts_set[`RTA_EV_SEC] = tod_tick;
		sts_set[`RTA_EV_MIN] = sec_cy;
		sts_set[`RTA_EV_HR] = min_cy;
		sts_set[`RTA_EV_DAY] = hr_cy;
		sts_set[`RTA_EV_ALM] = alm_hit;
		sts_set[`RTA_EV_WDG] = wd_to & wd_sel_q;
		sts_set[`RTA_EV_RATE_F] = rate_hit;
	end
	assign sts_clr = (wr_fire && aw_addr_q == `RTA_OFS_STS) ?
		16'(merge(32'h0, w_data_q, w_strb_q)) : 16'h0000;
	// R22: sticky, write one clears, set wins
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			sts_q <= 16'h0000;
		else
			sts_q <= (sts_q & ~sts_clr) | sts_set;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ena_q <= 16'h0000;
		else if (wr_fire && aw_addr_q == `RTA_OFS_ENA)
			ena_q <= 16'(merge({16'h0, ena_q}, w_data_q, w_strb_q));
	end
	// R8: gate by enables; R10: alarm too; R19: three lines
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_q <= '0;
		end else begin
			irq_q.clock <= |(sts_q & ena_q & `RTA_CLK_MASK);
			irq_q.periodic <= |(sts_q & ena_q & `RTA_RATE_MASK);
			irq_q.wdog <= sts_q[`RTA_EV_WDG] & ena_q[`RTA_EV_WDG];
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign irq_lines = irq_q;
	assign wdog_sys_reset = wd_rst_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	presc_ratio_a: assert property (tick_q |-> $past(presc_q) == $past(div_last)) // R2
		else $error("tick without full prescale");
	sec_wrap_a: assert property (sec_cy && !wr_fire |=> tod_q.sec == 6'h00) // R6
		else $error("seconds did not wrap");
	oor_clear_a: assert property (tod_tick && !wr_fire && tod_q.sec > `RTA_SEC_LAST
		|=> tod_q.sec == 6'h00 && $stable(tod_q.min)) // R5
		else $error("out of range seconds kept");
	day_bump_a: assert property (hr_cy && !wr_fire
		|=> day_q == 9'($past(day_q) + 9'h001) && tod_q.hr == 5'h00) // R7
		else $error("day rollover wrong");
	alarm_flag_a: assert property (alm_hit |=> sts_q[`RTA_EV_ALM]) // R9
		else $error("alarm flag missing");
	clock_irq_a: assert property (##1 irq_q.clock == $past(|(sts_q & ena_q & `RTA_CLK_MASK))) // R8
		else $error("clock line mismatch");
	wdog_reset_a: assert property (tick_q && wd_en_q && !wd_sel_q && wd_cnt_q == 2'h1 && !wr_fire
		|=> ##1 wd_rst_q) // R13
		else $error("watchdog reset missing");
	wdog_clear_a: assert property (wr_fire && aw_addr_q == `RTA_OFS_WDG |=> wd_cnt_q == 2'h0) // R15
		else $error("watchdog count not cleared");
	rate_stop_a: assert property (!run |-> rate_hit == 8'h00 ##1 !tick_q && presc_q == 16'h0000) // R18
		else $error("rates run while disabled");
	stw_hold_a: assert property (stw_q == `RTA_STW_HOLD && !wr_fire |=> stw_q == `RTA_STW_HOLD) // R21
		else $error("stopwatch left hold");
	flag_sticky_a: assert property (sts_set[`RTA_EV_SEC] |=> sts_q[`RTA_EV_SEC]) // R22
		else $error("set lost against clear");
endmodule // rta_top
`default_nettype wire

/* src/rta_regs.svh */
// Register map, field positions, reset values and timing counts of the clock unit
`ifndef RTA_REGS_SVH
`define RTA_REGS_SVH
// ****************************************
// Byte offsets
// ****************************************
`define RTA_OFS_TOD 8'h00
`define RTA_OFS_ALM 8'h04
`define RTA_OFS_CTL 8'h08
`define RTA_OFS_STS 8'h0C
`define RTA_OFS_ENA 8'h10
`define RTA_OFS_DAY 8'h14
`define RTA_OFS_ADY 8'h18
`define RTA_OFS_WDG 8'h1C
`define RTA_OFS_STW 8'h20
// ****************************************
// Field positions
// ****************************************
`define RTA_SEC_F 5:0
`define RTA_MIN_F 21:16
`define RTA_HR_F 28:24
`define RTA_DAY_F 8:0
`define RTA_STW_F 5:0
`define RTA_CTL_EN 7
`define RTA_CTL_REF 5
`define RTA_CTL_STW 4
`define RTA_WDG_EN 0
`define RTA_WDG_IRQ 1
`define RTA_WDG_CNT_F 9:8
`define RTA_EV_STW 0
`define RTA_EV_SEC 1
`define RTA_EV_MIN 2
`define RTA_EV_ALM 3
`define RTA_EV_DAY 4
`define RTA_EV_HR 5
`define RTA_EV_WDG 6
`define RTA_EV_RATE_F 15:8
`define RTA_CLK_MASK 16'h003F
`define RTA_RATE_MASK 16'hFF00
// ****************************************
// Limits and reset values
// ****************************************
`define RTA_SEC_LAST 6'h3B
`define RTA_HR_LAST 5'h17
`define RTA_STW_HOLD 6'h3F
`define RTA_WDG_LIMIT 2'h2
`define RTA_DIV_32K 16'h7FFF
`define RTA_DIV_38K 16'h95FF
`define RTA_TAP_MASK 16'h7FFF
`define RTA_RESP_OK 2'h0
`define RTA_RESP_ERR 2'h2
`endif

/* src/rta_pkg.sv */
// Types shared by the clock unit
package rta_pkg;
	typedef struct packed {
		logic wdog;
		logic periodic;
		logic clock;
	} rta_irq_type;
	typedef struct packed {
		logic [4:0] hr;
		logic [5:0] min;
		logic [5:0] sec;
	} rta_tod_type;
endpackage

/* bench/rta_bus_partner.sv */
// Register bus master and reference crystal facing the clock unit
`timescale 1ns/1ps
`default_nettype none
module rta_bus_partner (
	// Clock
	input wire logic mclk,
	// Reference crystal
	output logic slow_ref_clock,
	// Write side
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read side
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		slow_ref_clock = 1'b0;
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		wstrb = 4'hF;
		{araddr, arvalid, rready} = '0;
	end
	// Far faster than a crystal, so one second is 65536 cycles
	// In step with the bench clock, so each level is still sampled once
	always @(posedge mclk) begin
		slow_ref_clock <= ~slow_ref_clock;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge mclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge mclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		do @(posedge mclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge mclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule // rta_bus_partner
`default_nettype wire

/* bench/rta_top_bench.sv */
// Self-checking bench of the clock unit
`timescale 1ns/1ps
`default_nettype none
`include "rta_regs.svh"
module rta_top_bench;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [31:0] data;
		logic [31:0] exp;
		logic [1:0] resp;
	} rta_row_type;
	localparam int NROWS = 20;
	localparam rta_row_type ROWS [NROWS] = '{
		'{1'b0, `RTA_OFS_TOD, 32'h0, 32'h0, `RTA_RESP_OK},
		'{1'b0, `RTA_OFS_ALM, 32'h0, 32'h0, `RTA_RESP_OK},
		'{1'b0, `RTA_OFS_CTL, 32'h0, 32'h80, `RTA_RESP_OK},
		'{1'b0, `RTA_OFS_STS, 32'h0, 32'h0, `RTA_RESP_OK},
		'{1'b0, `RTA_OFS_ENA, 32'h0, 32'h0, `RTA_RESP_OK},
		'{1'b0, `RTA_OFS_DAY, 32'h0, 32'h0, `RTA_RESP_OK},
		'{1'b0, `RTA_OFS_ADY, 32'h0, 32'h0, `RTA_RESP_OK},
		'{1'b0, `RTA_OFS_WDG, 32'h0, 32'h1, `RTA_RESP_OK},
		'{1'b0, `RTA_OFS_STW, 32'h0, 32'h3F, `RTA_RESP_OK},
		'{1'b0, 8'h24, 32'h0, 32'h0, `RTA_RESP_ERR},
		'{1'b0, 8'h02, 32'h0, 32'h0, `RTA_RESP_ERR},
		'{1'b1, `RTA_OFS_TOD, 32'h173B003B, 32'h173B003B, `RTA_RESP_OK},
		'{1'b1, `RTA_OFS_DAY, 32'h5, 32'h5, `RTA_RESP_OK},
		'{1'b1, `RTA_OFS_ADY, 32'h6, 32'h6, `RTA_RESP_OK},
		'{1'b1, `RTA_OFS_ALM, 32'h0, 32'h0, `RTA_RESP_OK},
		'{1'b1, `RTA_OFS_ENA, 32'h3F, 32'h3F, `RTA_RESP_OK},
		'{1'b1, `RTA_OFS_CTL, 32'h90, 32'h90, `RTA_RESP_OK},
		'{1'b1, `RTA_OFS_STW, 32'h0, 32'h0, `RTA_RESP_OK},
		'{1'b1, `RTA_OFS_WDG, 32'h3, 32'h3, `RTA_RESP_OK},
		'{1'b1, 8'h24, 32'h1, 32'h0, `RTA_RESP_ERR}
	};
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic slow_ref_clock;
	logic [7:0] awaddr;
	logic awvalid;
	logic awready;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic wvalid;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready;
	logic [7:0] araddr;
	logic arvalid;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready;
	rta_pkg::rta_irq_type irq_lines;
	logic wdog_sys_reset;
	int miscompares = 0;
	int cmp_count = 0;
	always #5 mclk = ~mclk;
	rta_top i_rta_top (.mclk(mclk), .rstn(rstn), .slow_ref_clock(slow_ref_clock),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_lines(irq_lines),
		.wdog_sys_reset(wdog_sys_reset));
	rta_bus_partner i_rta_bus_partner (.mclk(mclk), .slow_ref_clock(slow_ref_clock),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		i_rta_bus_partner.wr(a, d, r);
		chk("bresp", 32'h0, {30'h0, r});
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		i_rta_bus_partner.rd(a, d, r);
		chk(what, exp, d & m);
	endtask
	task automatic wait_line(input int idx, input int limit);
		int n;
		n = 0;
		while (irq_lines[idx] !== 1'b1 && n < limit) begin
			@(posedge mclk);
			n++;
		end
		chk("irq wait", 32'h1, {31'h0, irq_lines[idx]});
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		for (int i = 0; i < NROWS; i++) begin
			if (ROWS[i].wr) begin
				i_rta_bus_partner.wr(ROWS[i].addr, ROWS[i].data, r);
				chk("bresp", {30'h0, ROWS[i].resp}, {30'h0, r});
			end
			i_rta_bus_partner.rd(ROWS[i].addr, d, r);
			chk("rdata", ROWS[i].exp, d);
			chk("rresp", {30'h0, ROWS[i].resp}, {30'h0, r});
		end
		$display("table done");
		wr_ok(`RTA_OFS_STS, 32'hFFFF);
		repeat (1100) @(posedge mclk);
		chk("periodic off", 32'h0, {31'h0, irq_lines.periodic});
		rd_chk("rate7 flag", `RTA_OFS_STS, 32'h8000, 32'h8000);
		wr_ok(`RTA_OFS_ENA, 32'h803F);
		repeat (4) @(posedge mclk);
		chk("periodic on", 32'h1, {31'h0, irq_lines.periodic});
		$display("rate gating done");
		wr_ok(`RTA_OFS_CTL, 32'h0);
		wr_ok(`RTA_OFS_WDG, 32'h0);
		// Rates frozen, so a fresh tap hit cannot refill the cleared flag
		wr_ok(`RTA_OFS_STS, 32'h8000);
		rd_chk("rate7 cleared", `RTA_OFS_STS, 32'h8000, 32'h0);
		wr_ok(`RTA_OFS_STS, 32'hFFFF);
		repeat (2100) @(posedge mclk);
		rd_chk("stopped flags", `RTA_OFS_STS, 32'hFFFF, 32'h0);
		chk("stopped line", 32'h0, {31'h0, irq_lines.periodic});
		wr_ok(`RTA_OFS_CTL, 32'h90);
		wr_ok(`RTA_OFS_WDG, 32'h3);
		wr_ok(`RTA_OFS_STS, 32'hFFFF);
		$display("rate stop done");
		wait_line(0, 70000);
		repeat (8) @(posedge mclk);
		rd_chk("time", `RTA_OFS_TOD, 32'hFFFFFFFF, 32'h0);
		rd_chk("day", `RTA_OFS_DAY, 32'h1FF, 32'h6);
		rd_chk("stopwatch", `RTA_OFS_STW, 32'h3F, 32'h3F);
		rd_chk("events", `RTA_OFS_STS, 32'hFF3F, 32'hFF3F);
		rd_chk("wdog count", `RTA_OFS_WDG, 32'h3FF, 32'h103);
		wr_ok(`RTA_OFS_WDG, 32'h3);
		rd_chk("wdog cleared", `RTA_OFS_WDG, 32'h3FF, 32'h3);
		chk("clock line", 32'h1, {31'h0, irq_lines.clock});
		wr_ok(`RTA_OFS_STS, 32'h3F);
		repeat (3) @(posedge mclk);
		chk("clock line off", 32'h0, {31'h0, irq_lines.clock});
		chk("no sys reset", 32'h0, {31'h0, wdog_sys_reset});
		$display("rollover done");
		final_report;
	end
	// Whole run is near 70000 cycles
	initial begin
		#1_000_000;
		miscompares++;
		$display("watchdog expired");
		final_report;
	end
endmodule // rta_top_bench
`default_nettype wire
